// *** logic/rcms_regs.svh ***
// Timing counts and fixed values of the reset, clock and mode-strap sequencer.
// Assumes REF_CLK is the oscillator input at 250 MHz and the divided clock is half of it.
`ifndef RCMS_REGS_SVH
`define RCMS_REGS_SVH

// Oscillator cycles in one period of the divided clock output.
`define RCMS_REF_PER_DIVIDED_CLOCK_OUT 2
// Reset output tail after release, in divided-clock periods.
`define RCMS_RST_TAIL_DIVIDED_CLOCK_OUT 2
`define RCMS_RST_TAIL_CYC (`RCMS_RST_TAIL_DIVIDED_CLOCK_OUT * `RCMS_REF_PER_DIVIDED_CLOCK_OUT)
// First fetch after release, in half divided-clock periods (6.5 periods).
`define RCMS_FETCH_HALF_DIVIDED_CLOCK_OUT 13
`define RCMS_FETCH_CYC ((`RCMS_FETCH_HALF_DIVIDED_CLOCK_OUT * `RCMS_REF_PER_DIVIDED_CLOCK_OUT) / 2)
// Strap second sample, in divided-clock periods after release.
`define RCMS_STRAP_DIVIDED_CLOCK_OUT 4
`define RCMS_STRAP_CYC (`RCMS_STRAP_DIVIDED_CLOCK_OUT * `RCMS_REF_PER_DIVIDED_CLOCK_OUT)
// Strap re-sample interval while suspended, in divided-clock periods.
`define RCMS_POLL_DIVIDED_CLOCK_OUT 5
`define RCMS_POLL_CYC (`RCMS_POLL_DIVIDED_CLOCK_OUT * `RCMS_REF_PER_DIVIDED_CLOCK_OUT)
// Width of the release counter and the poll counter.
`define RCMS_CNT_W 4
// Index of the cold start and strap bits in the synchroniser.
`define RCMS_SYNC_COLD 0
`define RCMS_SYNC_STRAP 1

`endif

// *** logic/rcms_pkg.sv ***
// Types shared by the reset, clock and mode-strap sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package rcms_pkg;

	// Sequencer states, one-hot.
	typedef enum logic [3:0] {
		RCMS_ST_HOLD = 4'h1,
		RCMS_ST_TAIL = 4'h2,
		RCMS_ST_BOOT = 4'h4,
		RCMS_ST_RUN = 4'h8
	} rcms_state_t;

	// Operating mode chosen at reset.
	typedef struct packed {
		logic enhanced;
		logic valid;
	} rcms_mode_t;

	// Status handed to the instruction core.
	typedef struct packed {
		logic run;
		logic suspend;
		logic int_service;
	} rcms_core_t;

endpackage : rcms_pkg

// *** logic/rcms_sync.sv ***
// Two flip-flop synchroniser for a group of level inputs.
// Assumes the inputs are levels from outside the REF_CLK domain.
module rcms_sync #(
	parameter int WIDTH = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1_reg;

	// The first stage feeds only the second; nothing else looks at it.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stage1_reg <= '1;
			sync_out <= '1;
		end else begin
			stage1_reg <= async_in;
			sync_out <= stage1_reg;
		end
	end

endmodule : rcms_sync

// *** logic/rcms_top.sv ***
// Reset, divided clock and mode-strap sequencer of an embedded processor.
// Assumes REF_CLK is the oscillator input; pins arrive unsynchronised.
`include "rcms_regs.svh"

module rcms_top (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RST_N,
	// Board pins
	input wire logic COLD_START_IN_N,
	input wire logic STRAP_IN,
	output logic STRAP_OUT,
	output logic STRAP_OE_N,
	output logic DIVIDED_CLOCK_OUT,
	output logic SYS_RESET_OUT,
	// Core side
	input wire logic WAIT_START,
	input wire logic INT_ENABLE,
	input wire logic INT_PENDING,
	output rcms_pkg::rcms_core_t CORE,
	output rcms_pkg::rcms_mode_t MODE,
	output logic STRAP_DIR_SET
);

	localparam int TAIL_CYC = `RCMS_RST_TAIL_CYC;
	localparam int FETCH_CYC = `RCMS_FETCH_CYC;
	localparam int STRAP_CYC = `RCMS_STRAP_CYC;
	localparam int POLL_CYC = `RCMS_POLL_CYC;

	logic [1:0] pins_sync;
	logic res_active;
	logic strap_hi;
	logic tick;
	logic clk_div_reg;
	logic sys_rst_reg;
	logic [`RCMS_CNT_W-1:0] cnt_reg;
	logic [`RCMS_CNT_W-1:0] poll_reg;
	logic strap_at_rise_reg;
	logic enhanced_reg;
	logic mode_valid_reg;
	logic suspend_reg;
	logic dir_set_reg;
	rcms_pkg::rcms_state_t state_reg;
	rcms_pkg::rcms_state_t state_next;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisation.

	rcms_sync #(
		.WIDTH(2)
	) u_sync (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.async_in({STRAP_IN, COLD_START_IN_N}),
		.sync_out(pins_sync)
	);

	assign res_active = !pins_sync[`RCMS_SYNC_COLD];
	assign strap_hi = pins_sync[`RCMS_SYNC_STRAP];

	////////////////////////////////////////////////////////////////////////////////
	// Clock divider.

	// No term of the cold start input or bus hold can stop the toggle; only RST_N holds it low.
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			clk_div_reg <= 1'b0;
		end else begin
			clk_div_reg <= !clk_div_reg;
		end
	end

	// even duty enable
	// One pulse per divided period, in the cycle before its rising edge.
	assign tick = !clk_div_reg;
	assign DIVIDED_CLOCK_OUT = clk_div_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Reset sequence.

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			rcms_pkg::RCMS_ST_HOLD: begin
				if (!res_active && tick) begin
					state_next = rcms_pkg::RCMS_ST_TAIL;
				end
			end
			rcms_pkg::RCMS_ST_TAIL: begin
				if (cnt_reg == `RCMS_CNT_W'(TAIL_CYC - 1)) begin
					state_next = rcms_pkg::RCMS_ST_BOOT;
				end
			end
			rcms_pkg::RCMS_ST_BOOT: begin
				if (cnt_reg == `RCMS_CNT_W'(FETCH_CYC - 1)) begin
					state_next = rcms_pkg::RCMS_ST_RUN;
				end
			end
			rcms_pkg::RCMS_ST_RUN: begin
				state_next = rcms_pkg::RCMS_ST_RUN;
			end
			default: begin
				state_next = rcms_pkg::RCMS_ST_HOLD;
			end
		endcase
		if (res_active) begin
			state_next = rcms_pkg::RCMS_ST_HOLD;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			state_reg <= rcms_pkg::RCMS_ST_HOLD;
		end else begin
			state_reg <= state_next;
		end
	end

	// fetch after release
	// Counts oscillator cycles from the aligned release up to the first fetch.
	always_ff @(posedge REF_CLK) begin
		if (!RST_N || state_next == rcms_pkg::RCMS_ST_HOLD) begin
			cnt_reg <= '0;
		end else if (state_reg != rcms_pkg::RCMS_ST_HOLD && state_reg != rcms_pkg::RCMS_ST_RUN) begin
			cnt_reg <= cnt_reg + `RCMS_CNT_W'(1);
		end
	end

	// always driven
	// The output only moves on a divided-clock edge, so its length is whole periods.
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			sys_rst_reg <= 1'b1;
		end else if (res_active && tick) begin
			sys_rst_reg <= 1'b1;
		end else if (state_reg == rcms_pkg::RCMS_ST_TAIL &&
			cnt_reg == `RCMS_CNT_W'(TAIL_CYC - 1)) begin
			sys_rst_reg <= 1'b0;
		end
	end

	assign SYS_RESET_OUT = sys_rst_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Mode strap.

	// input by reset
	// The strap pin is never driven; the flag shows its direction is settled.
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			dir_set_reg <= 1'b0;
		end else if (res_active) begin
			dir_set_reg <= 1'b1;
		end
	end

	assign STRAP_OUT = 1'b0;
	assign STRAP_OE_N = 1'b1;
	assign STRAP_DIR_SET = dir_set_reg;

	always_ff @(posedge REF_CLK) begin
		if (!RST_N || res_active) begin
			strap_at_rise_reg <= 1'b0;
			enhanced_reg <= 1'b0;
			mode_valid_reg <= 1'b0;
		end else if (state_reg == rcms_pkg::RCMS_ST_HOLD &&
			state_next == rcms_pkg::RCMS_ST_TAIL) begin
			strap_at_rise_reg <= strap_hi;
		end else if (!mode_valid_reg && cnt_reg == `RCMS_CNT_W'(STRAP_CYC - 1)) begin
			enhanced_reg <= strap_at_rise_reg && !strap_hi;
			mode_valid_reg <= 1'b1;
		end
	end

	assign MODE.enhanced = enhanced_reg;
	assign MODE.valid = mode_valid_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Wait-for-pin.

	always_ff @(posedge REF_CLK) begin
		if (!RST_N || state_reg != rcms_pkg::RCMS_ST_RUN || res_active) begin
			suspend_reg <= 1'b0;
			poll_reg <= '0;
		end else if (!suspend_reg) begin
			suspend_reg <= WAIT_START && strap_hi;
			poll_reg <= '0;
		end else if (poll_reg == `RCMS_CNT_W'(POLL_CYC - 1)) begin
			suspend_reg <= strap_hi;
			poll_reg <= '0;
		end else begin
			poll_reg <= poll_reg + `RCMS_CNT_W'(1);
		end
	end

	assign CORE.run = (state_reg == rcms_pkg::RCMS_ST_RUN);
	assign CORE.suspend = suspend_reg;
	assign CORE.int_service = suspend_reg && INT_ENABLE && INT_PENDING;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	property p_div_toggle;
		@(posedge REF_CLK) disable iff (!RST_N)
		DIVIDED_CLOCK_OUT |=> !DIVIDED_CLOCK_OUT ##1 DIVIDED_CLOCK_OUT;
	endproperty
	a_div_toggle: assert property (p_div_toggle) else $error("divided clock not halving");
	property p_rst_assert;
		@(posedge REF_CLK) disable iff (!RST_N)
		(res_active && tick) |=> SYS_RESET_OUT && DIVIDED_CLOCK_OUT;
	endproperty
	a_rst_assert: assert property (p_rst_assert) else $error("reset output not set");
	property p_rst_tail;
		@(posedge REF_CLK) disable iff (!RST_N)
		$fell(SYS_RESET_OUT) |-> cnt_reg == TAIL_CYC && DIVIDED_CLOCK_OUT;
	endproperty
	a_rst_tail: assert property (p_rst_tail) else $error("reset tail length wrong");
	property p_abort;
		@(posedge REF_CLK) disable iff (!RST_N)
		res_active |=> !CORE.run && !CORE.suspend && state_reg == rcms_pkg::RCMS_ST_HOLD;
	endproperty
	a_abort: assert property (p_abort) else $error("activity not aborted");
	property p_leave_hold;
		@(posedge REF_CLK) disable iff (!RST_N)
		(state_reg == rcms_pkg::RCMS_ST_HOLD ##1 state_reg != rcms_pkg::RCMS_ST_HOLD) |->
			$past(pins_sync[`RCMS_SYNC_COLD]);
	endproperty
	a_leave_hold: assert property (p_leave_hold) else $error("left hold unsynchronised");
	property p_fetch;
		@(posedge REF_CLK) disable iff (!RST_N)
		$rose(CORE.run) |-> $past(cnt_reg) == FETCH_CYC - 1 && $past(SYS_RESET_OUT, 10) == 1'b1;
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch start mistimed");
	property p_mode;
		@(posedge REF_CLK) disable iff (!RST_N)
		$rose(MODE.valid) |-> MODE.enhanced == ($past(strap_at_rise_reg) && !$past(strap_hi));
	endproperty
	a_mode: assert property (p_mode) else $error("mode decode wrong");
	property p_mode_hold;
		@(posedge REF_CLK) disable iff (!RST_N)
		(MODE.valid && !res_active) |=> $stable(MODE.enhanced) || res_active;
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode changed after latch");
	property p_suspend;
		@(posedge REF_CLK) disable iff (!RST_N || res_active)
		(CORE.run && !CORE.suspend && WAIT_START && strap_hi) |=> CORE.suspend;
	endproperty
	a_suspend: assert property (p_suspend) else $error("wait did not suspend");
	property p_resume;
		@(posedge REF_CLK) disable iff (!RST_N || res_active)
		$fell(CORE.suspend) && CORE.run |-> !$past(strap_hi) && $past(poll_reg) == POLL_CYC - 1;
	endproperty
	a_resume: assert property (p_resume) else $error("resume off the poll slot");
	property p_int;
		@(posedge REF_CLK) disable iff (!RST_N)
		(CORE.suspend && INT_ENABLE && INT_PENDING) |-> CORE.int_service;
	endproperty
	a_int: assert property (p_int) else $error("interrupt not serviced");
	property p_dir;
		@(posedge REF_CLK) disable iff (!RST_N)
		res_active |=> STRAP_DIR_SET && STRAP_OE_N;
	endproperty
	a_dir: assert property (p_dir) else $error("strap not made input");

	c_boot: cover property (@(posedge REF_CLK) disable iff (!RST_N) $rose(CORE.run));
	c_enh: cover property (@(posedge REF_CLK) disable iff (!RST_N) $rose(MODE.valid) && MODE.enhanced);
	c_resume: cover property (@(posedge REF_CLK) disable iff (!RST_N) $fell(CORE.suspend));
	c_int: cover property (@(posedge REF_CLK) disable iff (!RST_N) CORE.int_service);

endmodule : rcms_top

// *** tb/rcms_board_model.sv ***
// Board side of the sequencer: reset circuit and strap pin with weak pull-up.
// Assumes the bench calls its tasks at a falling edge of clk.
module rcms_board_model (
	// Clock
	input wire logic clk,
	// Board pins
	output logic cold_n,
	input wire logic strap_oe_n,
	input wire logic strap_out,
	output logic strap_level
);
	timeunit 1ns;
	timeprecision 1ps;
	logic drv_en = 1'b0;
	logic drv_val = 1'b0;
	initial cold_n = 1'b1;
	// Strap level, pulled up when released.
	assign strap_level = !strap_oe_n ? strap_out : (drv_en ? drv_val : 1'b1);

	task automatic press_reset(input int cycles);
		int n;
		n = (cycles < 10) ? 10 : cycles;
		cold_n = 1'b0;
		repeat (n) @(negedge clk);
		cold_n = 1'b1;
	endtask : press_reset

	task automatic set_strap(input logic en, input logic val);
		drv_en = en;
		drv_val = val;
	endtask : set_strap
endmodule : rcms_board_model

// *** tb/tb_top.sv ***
// Self-checking bench of the reset, clock and mode-strap sequencer.
// Assumes the board model drives the reset and strap pins.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk;
	logic rst_n = 1'b0;
	logic cold_n;
	logic strap_in;
	logic strap_out;
	logic strap_oe_n;
	logic div_clk;
	logic sys_rst;
	logic wait_start = 1'b0;
	logic int_en = 1'b0;
	logic int_pend = 1'b0;
	rcms_pkg::rcms_core_t core;
	rcms_pkg::rcms_mode_t mode;
	logic dir_set;
	int bad_count = 0;
	int num_checks = 0;
	int ka;
	int kb;

	rcms_top rcms_top_i (
		.REF_CLK(ref_clk), .RST_N(rst_n), .COLD_START_IN_N(cold_n), .STRAP_IN(strap_in),
		.STRAP_OUT(strap_out), .STRAP_OE_N(strap_oe_n), .DIVIDED_CLOCK_OUT(div_clk),
		.SYS_RESET_OUT(sys_rst), .WAIT_START(wait_start), .INT_ENABLE(int_en),
		.INT_PENDING(int_pend), .CORE(core), .MODE(mode), .STRAP_DIR_SET(dir_set)
	);
	rcms_board_model rcms_board_model_i (
		.clk(ref_clk), .cold_n(cold_n), .strap_oe_n(strap_oe_n),
		.strap_out(strap_out), .strap_level(strap_in)
	);

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
			bad_count++;
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : tick

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test

	// Strap is low at release, or high and then either kept high or dropped after the reset tail.
	task automatic cold_start(input logic low_strap, input logic drop, input logic enh);
		int k;
		logic p;
		rcms_board_model_i.set_strap(low_strap, 1'b0);
		fork
			rcms_board_model_i.press_reset(12);
			begin
				tick(8);
				check("reset out held", sys_rst, 1);
				check("core cleared", core, 0);
				check("mode cleared", mode, 0);
				p = div_clk;
				tick(1);
				check("clock toggles in reset", div_clk, !p);
				tick(1);
				check("clock toggles again", div_clk, p);
			end
		join
		k = 0;
		while (sys_rst === 1'b1 && k < 20) begin
			tick(1);
			k++;
		end
		check("reset tail", 8'(k == 7 || k == 8), 1);
		check("reset aligned to clock rise", div_clk, 1);
		if (drop)
			rcms_board_model_i.set_strap(1'b1, 1'b0);
		tick(3);
		check("mode not yet valid", mode.valid, 0);
		tick(1);
		check("mode valid", mode.valid, 1);
		check("mode enhanced", mode.enhanced, enh);
		tick(4);
		check("no fetch yet", core.run, 0);
		tick(1);
		check("fetch starts", core.run, 1);
		check("strap direction set", dir_set, 1);
		$display("test cold start done");
	endtask : cold_start

	// Suspend on a high strap, hold it high for a while, then drop it.
	// The hold is at least two cycles, as the interrupt checks use the first two.
	task automatic wait_pin(input int hold, input logic enh, output int k);
		rcms_board_model_i.set_strap(1'b0, 1'b0);
		tick(3);
		wait_start = 1'b1;
		tick(1);
		wait_start = 1'b0;
		k = 1;
		check("suspended", core.suspend, 1);
		int_en = 1'b1;
		int_pend = 1'b1;
		tick(1);
		check("interrupt serviced", core.int_service, 1);
		int_en = 1'b0;
		tick(1);
		check("interrupt masked", core.int_service, 0);
		int_pend = 1'b0;
		tick(hold - 2);
		k += hold;
		check("still suspended", core.suspend, 1);
		rcms_board_model_i.set_strap(1'b1, 1'b0);
		while (core.suspend === 1'b1 && k < 40) begin
			tick(1);
			k++;
		end
		check("resumed", core.suspend, 0);
		check("mode held", mode.enhanced, enh);
		$display("test wait for pin done");
	endtask : wait_pin

	task automatic no_suspend();
		rcms_board_model_i.set_strap(1'b1, 1'b0);
		tick(3);
		wait_start = 1'b1;
		tick(1);
		wait_start = 1'b0;
		tick(2);
		check("low strap no suspend", core.suspend, 0);
		$display("test no suspend done");
	endtask : no_suspend

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(negedge ref_clk);
		rst_n = 1'b1;
		tick(4);
		check("direction unset", dir_set, 0);
		check("strap pin undriven", strap_oe_n, 1);
		check("strap pin output low", strap_out, 0);
		cold_start(1'b0, 1'b1, 1'b1);
		wait_pin(2, 1'b1, ka);
		wait_pin(12, 1'b1, kb);
		check("poll period", 8'(kb - ka), 8'h0a);
		no_suspend();
		rcms_board_model_i.set_strap(1'b0, 1'b0);
		tick(3);
		wait_start = 1'b1;
		tick(1);
		wait_start = 1'b0;
		check("suspended before cold start", core.suspend, 1);
		// A cold start in mid-suspend must clear it; a steady high strap gives compatible.
		cold_start(1'b0, 1'b0, 1'b0);
		cold_start(1'b1, 1'b0, 1'b0);
		end_of_test();
	end

	initial begin
		repeat (3000) @(posedge ref_clk);
		bad_count++;
		$display("watchdog expired");
		end_of_test();
	end
endmodule : tb_top
